// ==== verilog/mpk_pkg.sv ====
// Shared constants and types for the power key and reset sequencer ends
package mpk_pkg;
    // ---------------------------------------------------------------
    // Timebase
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned MS_CNT_W        = 16;
    localparam int unsigned DIV_W           = 16;
    localparam logic [DIV_W-1:0] DIV_LAST   = DIV_W'(CLK_PER_MS - 1);
    // ---------------------------------------------------------------
    // Times in milliseconds
    // ---------------------------------------------------------------
    localparam logic [MS_CNT_W-1:0] T_ON_MS       = 16'd500;
    localparam logic [MS_CNT_W-1:0] T_OFF_MS      = 16'd650;
    localparam logic [MS_CNT_W-1:0] T_RST_MIN_MS  = 16'd150;
    localparam logic [MS_CNT_W-1:0] T_RST_MAX_MS  = 16'd460;
    localparam logic [MS_CNT_W-1:0] T_VBAT_MS     = 16'd30;
    localparam logic [MS_CNT_W-1:0] T_BOOT_MS     = 16'd20;
    localparam logic [MS_CNT_W-1:0] T_HALT_MS     = 16'd20;
    localparam logic [MS_CNT_W-1:0] T_HOST_OFF_MS = 16'd700;
    localparam logic [MS_CNT_W-1:0] T_HOST_RST_MS = 16'd300;
    localparam logic [MS_CNT_W-1:0] MS_SAT        = 16'hFFFF;

    // ---------------------------------------------------------------
    // Module states, Gray along power-on, run, power-off
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        MPK_OFF   = 3'b000,
        MPK_BOOT  = 3'b001,
        MPK_RUN   = 3'b011,
        MPK_HALT  = 3'b010,
        MPK_RESET = 3'b110
    } mpk_dev_e;

    // Host states
    typedef enum logic [2:0] {
        MPK_H_SETTLE = 3'b000,
        MPK_H_IDLE   = 3'b001,
        MPK_H_PRESS  = 3'b011,
        MPK_H_REL    = 3'b010,
        MPK_H_RST    = 3'b110
    } mpk_host_e;
endpackage

// ==== verilog/mpk_if.sv ====
// Pin-level link between host and module
`timescale 1ns/10ps
interface mpk_if;
    logic power_key_n_o;
    logic power_key_n_oe;
    logic reset_n_o;
    logic reset_n_oe;
    logic status;
    logic power_key_n;
    logic reset_n;

    // Open-drain lines with pull-up
    assign power_key_n = !(power_key_n_oe && !power_key_n_o);
    assign reset_n     = !(reset_n_oe && !reset_n_o);

    modport host (
        output power_key_n_o, power_key_n_oe, reset_n_o, reset_n_oe,
        input  status, power_key_n, reset_n
    );
    modport dev (
        input  power_key_n, reset_n,
        output status
    );
endinterface

// ==== verilog/mpk_dev.sv ====
// Module end: power key, reset and shutdown sequencing
`timescale 1ns/10ps
// How it works
// R1 - Key low 500 ms powers module on
// R2 - Host holds key until status high
// R3 - Status high only while powered on
// R4 - Host waits 30 ms after supply
// R5 - Key low 650 ms, off on release
// R6 - Software shutdown uses same power-off
// R7 - Key low after shutdown restarts module
// R8 - Supply cut only after shutdown completes
// R9 - Reset pulse 150 to 460 ms resets
// R10 - Reset only after shutdowns failed; host resets on any req_reset while idle and status is high
// R11 - Key driven open-drain or button
// R12 - Key tied low means auto power-on
// R13 - Millisecond counter; short presses ignored
module mpk_dev
    import mpk_pkg::*;
#(
    parameter int unsigned CLK_PER_MS_P = CLK_PER_MS
)
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    mpk_if.dev        link,
    input  wire logic software_shutdown_command,
    output logic      running,
    output logic      reset_pulse
);
    // ---------------------------------------------------------------
    // Local constants
    // ---------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(CLK_PER_MS_P - 1);
    localparam int               N_PIN   = 2;
    localparam int               PIN_KEY = 0;
    localparam int               PIN_RST = 1;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Saturating step, so a line held low for ever cannot wrap round
    function automatic logic [MS_CNT_W-1:0] ms_step(
        input logic [MS_CNT_W-1:0] cnt,
        input logic                tick
    );
        ms_step = (tick && cnt != MS_SAT) ? cnt + 1'b1 : cnt;
    endfunction

    // True while the module counts as powered on
    function automatic logic is_up(input mpk_dev_e st);
        is_up = st == MPK_RUN;
    endfunction

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    wire  [N_PIN-1:0] pin_raw = {link.reset_n, link.power_key_n};
    logic [N_PIN-1:0] pin_low;
    logic [N_PIN-1:0] pin_rise;

    // A level counts once flops two and three agree, so a glitch
    // shorter than two cycles never reaches the timers
    genvar gi;
    generate
        for (gi = 0; gi < N_PIN; gi++) begin : g_pin
            logic [2:0] sync_r;
            logic       low_r;
            wire        agree = sync_r[1] == sync_r[2];

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    sync_r <= 3'h7;
                    low_r  <= 1'b0;
                end else begin
                    sync_r <= {sync_r[1:0], pin_raw[gi]};
                    if (agree) low_r <= !sync_r[2];
                end
            end

            assign pin_low[gi]  = low_r;
            // Agreed high while still marked low: the release edge
            assign pin_rise[gi] = low_r && agree && sync_r[2];
        end
    endgenerate

    wire key_low  = pin_low[PIN_KEY];
    wire key_rise = pin_rise[PIN_KEY];
    wire rst_low  = pin_low[PIN_RST];
    wire rst_rise = pin_rise[PIN_RST];

    // ---------------------------------------------------------------
    // Millisecond timebase
    // ---------------------------------------------------------------
    logic [DIV_W-1:0] div_r;
    wire              ms_tick = div_r == DIV_TOP;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) div_r <= '0;
        else         div_r <= ms_tick ? '0 : div_r + 1'b1;
    end

    // ---------------------------------------------------------------
    // Low-time counters for key and reset
    // ---------------------------------------------------------------
    logic [MS_CNT_W-1:0] key_ms_r;
    logic [MS_CNT_W-1:0] rst_ms_r;

    wire key_on_ok  = key_ms_r >= T_ON_MS;       // R1
    wire key_off_ok = key_ms_r >= T_OFF_MS;      // R5
    wire rst_in_win = rst_ms_r >= T_RST_MIN_MS && rst_ms_r <= T_RST_MAX_MS;
    // Pulses shorter or longer than the window are dropped
    wire rst_fire   = rst_rise && rst_in_win;    // R9

    // Counts restart at zero on every release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            key_ms_r <= '0;
            rst_ms_r <= '0;
        end else begin
            key_ms_r <= key_low ? ms_step(key_ms_r, ms_tick) : '0; // R13
            rst_ms_r <= rst_low ? ms_step(rst_ms_r, ms_tick) : '0;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    mpk_dev_e            state_r;
    mpk_dev_e            state_nxt;
    logic [MS_CNT_W-1:0] seq_ms_r;
    logic                long_press_r;

    wire seq_done        = ms_tick && seq_ms_r >= T_BOOT_MS;
    wire halt_done       = ms_tick && seq_ms_r >= T_HALT_MS;
    wire off_to_boot     = key_on_ok;                        // R1
    wire boot_to_run     = seq_done;
    wire run_to_reset    = rst_fire;                         // R9
    wire run_to_halt_sw  = software_shutdown_command;        // R6
    wire run_to_halt_key = long_press_r && key_rise;         // R5
    wire halt_to_boot    = halt_done && key_low;             // R7
    wire halt_to_off     = halt_done && !key_low;
    wire reset_to_boot   = seq_done;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MPK_OFF: begin
                if (off_to_boot) state_nxt = MPK_BOOT;
            end
            MPK_BOOT: begin
                if (boot_to_run) state_nxt = MPK_RUN;
            end
            MPK_RUN: begin
                // Reset wins over a shutdown seen in the same cycle
                if (run_to_reset) state_nxt = MPK_RESET;
                else if (run_to_halt_sw) state_nxt = MPK_HALT;
                else if (run_to_halt_key) state_nxt = MPK_HALT;
            end
            MPK_HALT: begin
                // Key still low at the end powers straight back up
                if (halt_to_boot) state_nxt = MPK_BOOT;
                else if (halt_to_off) state_nxt = MPK_OFF;
            end
            MPK_RESET: begin
                // A reset always boots again, whatever the key does
                if (reset_to_boot) state_nxt = MPK_BOOT;
            end
            default: state_nxt = MPK_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) state_r <= MPK_OFF;
        else         state_r <= state_nxt;
    end

    // Time spent in the current state, restarted on every change
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)                   seq_ms_r <= '0;
        else if (state_nxt != state_r) seq_ms_r <= '0;
        else                           seq_ms_r <= ms_step(seq_ms_r, ms_tick);
    end

    // Cleared outside run; the power-on press arms it only if held that long
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) long_press_r <= 1'b0;
        else         long_press_r <= is_up(state_r) && (long_press_r || key_off_ok); // R5
    end

    // ---------------------------------------------------------------
    // Outputs, all registered
    // ---------------------------------------------------------------
    wire enter_reset = state_nxt == MPK_RESET && state_r != MPK_RESET;

    // Driven from the next state so status moves with the state itself
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            running     <= 1'b0;
            reset_pulse <= 1'b0;
            link.status <= 1'b0;
        end else begin
            running     <= is_up(state_nxt);
            reset_pulse <= enter_reset;                  // R9
            link.status <= is_up(state_nxt);             // R3
        end
    end
endmodule

// ==== verilog/mpk_host.sv ====
// Host end: drives power key and reset on request
`timescale 1ns/10ps
module mpk_host
    import mpk_pkg::*;
#(
    parameter int unsigned CLK_PER_MS_P = CLK_PER_MS
)
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    mpk_if.host       link,
    input  wire logic req_on,
    input  wire logic req_off,
    input  wire logic req_reset,
    output logic      busy,
    output logic      module_up
);
    // ---------------------------------------------------------------
    // Status synchroniser and timebase
    // ---------------------------------------------------------------
    logic [2:0]          st_sync_r;
    logic                st_r;
    logic [DIV_W-1:0]    div_r;
    logic [MS_CNT_W-1:0] ms_r;
    localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(CLK_PER_MS_P - 1);
    wire                 ms_tick = div_r == DIV_TOP;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_sync_r <= 3'h0;
            st_r      <= 1'b0;
            div_r     <= '0;
        end else begin
            st_sync_r <= {st_sync_r[1:0], link.status};
            if (st_sync_r[1] == st_sync_r[2]) st_r <= st_sync_r[2];
            div_r <= ms_tick ? '0 : div_r + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    mpk_host_e state_r;
    mpk_host_e state_nxt;
    logic      off_r;
    logic      off_nxt;

    always_comb begin
        state_nxt = state_r;
        off_nxt   = off_r;
        case (state_r)
            MPK_H_SETTLE: begin
                if (ms_tick && ms_r >= T_VBAT_MS) state_nxt = MPK_H_IDLE; // R4
            end
            MPK_H_IDLE: begin
                // Reset takes priority over off and on requests, used only when asked for
                if (req_reset && st_r) state_nxt = MPK_H_RST;      // R10
                else if (req_off && st_r) begin
                    state_nxt = MPK_H_PRESS;
                    off_nxt   = 1'b1;
                end else if (req_on && !st_r) begin
                    state_nxt = MPK_H_PRESS;
                    off_nxt   = 1'b0;
                end
            end
            MPK_H_PRESS: begin
                // On: hold until status rises; off: hold past threshold
                if (!off_r && st_r && ms_r >= T_ON_MS) state_nxt = MPK_H_REL; // R2
                else if (off_r && ms_tick && ms_r >= T_HOST_OFF_MS)
                    state_nxt = MPK_H_REL;                         // R5
            end
            MPK_H_REL: begin
                // Key stays high until module settles, supply untouched
                if (off_r ? !st_r : ms_tick) state_nxt = MPK_H_IDLE; // R8
            end
            MPK_H_RST: begin
                if (ms_tick && ms_r >= T_HOST_RST_MS) state_nxt = MPK_H_IDLE; // R9
            end
            default: state_nxt = MPK_H_SETTLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r             <= MPK_H_SETTLE;
            off_r               <= 1'b0;
            ms_r                <= '0;
            link.power_key_n_o  <= 1'b0;
            link.power_key_n_oe <= 1'b0;
            link.reset_n_o      <= 1'b0;
            link.reset_n_oe     <= 1'b0;
            busy                <= 1'b1;
            module_up           <= 1'b0;
        end else begin
            state_r <= state_nxt;
            off_r   <= off_nxt;
            if (state_nxt != state_r) ms_r <= '0;
            else if (ms_tick && ms_r != MS_SAT) ms_r <= ms_r + 1'b1;
            // Open-drain: only ever pull low
            link.power_key_n_oe <= state_nxt == MPK_H_PRESS;       // R11
            link.reset_n_oe     <= state_nxt == MPK_H_RST;
            busy      <= state_nxt != MPK_H_IDLE;
            module_up <= st_r;
        end
    end
endmodule

// ==== verification/mpk_monitor.sv ====
// Checker on the host to module pin link
`timescale 1ns/10ps
module mpk_monitor
    import mpk_pkg::*;
#(
    parameter int MS = int'(CLK_PER_MS)
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic power_key_n_o,
    input wire logic power_key_n_oe,
    input wire logic reset_n_o,
    input wire logic reset_n_oe,
    input wire logic status,
    input wire logic power_key_n,
    input wire logic reset_n
);
    // ----
    // Helper counters
    // ----
    logic [31:0] since_r;
    logic [31:0] key_r;
    logic [31:0] rlo_r;
    logic [31:0] dwait_r;
    logic [31:0] rwait_r;
    logic        drop_r;
    logic        rec_r;
    logic        st_q_r;
    // Lengths are read at the first high sample, before the counter clears
    wire logic   key_up   = power_key_n && (key_r != 32'h0);
    wire logic   long_rel = key_up && status && (key_r >= int'(T_OFF_MS) * MS);
    wire logic   rst_ok   = reset_n && (rlo_r >= int'(T_RST_MIN_MS) * MS)
                            && (rlo_r <= int'(T_RST_MAX_MS) * MS) && status;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {since_r, key_r, rlo_r, dwait_r, rwait_r} <= '0;
            {drop_r, rec_r, st_q_r} <= 3'h0;
        end else begin
            if (since_r != 32'hFFFFFFFF) since_r <= since_r + 32'h1;
            key_r   <= power_key_n ? 32'h0 : key_r + 32'h1;
            rlo_r   <= reset_n ? 32'h0 : rlo_r + 32'h1;
            drop_r  <= (drop_r || long_rel || rst_ok) && status;
            dwait_r <= drop_r ? dwait_r + 32'h1 : 32'h0;
            st_q_r  <= status;
            rec_r   <= rst_ok || (rec_r && !(status && !st_q_r));
            rwait_r <= rec_r ? rwait_r + 32'h1 : 32'h0;
        end
    end
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_KEY_HELD: assert property ($rose(power_key_n) |-> $past(status))
        else $error("key released before status high");
    AST_VBAT_WAIT: assert property ($fell(power_key_n) |-> since_r >= 30 * MS)
        else $error("key pressed too soon after supply");
    AST_ON_PRESS: assert property ($rose(status) && !rec_r |-> key_r >= 500 * MS)
        else $error("status rose without a long enough press");
    AST_OFF_ON_RELEASE: assert property ($fell(status) |-> power_key_n)
        else $error("status fell while key still low");
    AST_SHORT_IGNORED: assert property (key_up && status && !long_rel |=> status [*8])
        else $error("short press turned module off");
    AST_DROP_BOUND: assert property (dwait_r <= 2 * MS)
        else $error("status did not fall after off or reset request");
    AST_RST_BACK: assert property (rwait_r <= 45 * MS)
        else $error("module did not come back after reset");
    AST_RST_WINDOW: assert property ($rose(reset_n) |-> rlo_r >= 150 * MS && rlo_r <= 460 * MS)
        else $error("reset pulse outside its window");
    AST_OPEN_DRAIN: assert property (power_key_n_oe || reset_n_oe |-> !power_key_n_o && !reset_n_o)
        else $error("host drove a line high");
    cover property ($rose(status));
    cover property (long_rel);
    cover property (rst_ok);
endmodule

// ==== verification/tb_top.sv ====
// Testbench for the host and module ends of the power key link
`timescale 1ns/10ps
module tb_top
    import mpk_pkg::*;
;
    // Scaled millisecond: all timing is whole ms, so only the run length shrinks
    localparam int MS = 20;
    logic ref_clk;
    logic resetn;
    logic req_on;
    logic req_off;
    logic req_reset;
    logic sw_cmd;
    logic busy;
    logic module_up;
    logic running;
    logic reset_pulse;
    int   num_errors;
    int   n_checks;
    int   n_pulse;
    mpk_if link ();
    mpk_dev #(.CLK_PER_MS_P(MS)) mpk_dev_inst (.ref_clk(ref_clk), .resetn(resetn), .link(link),
        .software_shutdown_command(sw_cmd), .running(running), .reset_pulse(reset_pulse));
    mpk_host #(.CLK_PER_MS_P(MS)) mpk_host_inst (.ref_clk(ref_clk), .resetn(resetn),
        .link(link), .req_on(req_on),
        .req_off(req_off), .req_reset(req_reset), .busy(busy), .module_up(module_up));
    mpk_monitor #(.MS(MS)) mpk_monitor_inst (.ref_clk(ref_clk), .resetn(resetn),
        .power_key_n_o(link.power_key_n_o), .power_key_n_oe(link.power_key_n_oe),
        .reset_n_o(link.reset_n_o), .reset_n_oe(link.reset_n_oe), .status(link.status),
        .power_key_n(link.power_key_n), .reset_n(link.reset_n));
    // ----
    // Clock, tasks, watchdog
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (reset_pulse === 1'b1) n_pulse++;
    task check(input string name, input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait on busy (sel 0) or status (sel 1); running out counts as a mismatch
    task wait_for(input int sel, input logic v, input int max_ms);
        logic s;
        s = 1'bx;
        for (int i = 0; i < max_ms * MS; i++) begin
            @(negedge ref_clk);
            s = (sel == 1) ? link.status : busy;
            if (s === v) break;
        end
        check(sel == 1 ? "status" : "busy", s, v);
    endtask
    task request(input int k);
        @(negedge ref_clk);
        {req_on, req_off, req_reset} = 3'h4 >> k;
        @(negedge ref_clk);
        {req_on, req_off, req_reset} = 3'h0;
    endtask
    initial begin
        repeat (2700) repeat (MS) @(posedge ref_clk);
        num_errors++;
        $display("BAD watchdog expected done seen hang");
        finish_test;
    end
    // ----
    // Test sequence
    // ----
    initial begin
        {resetn, req_on, req_off, req_reset, sw_cmd} = 5'h00;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk) resetn = 1'b1;
        check("status", link.status, 1'b0);
        check("busy", busy, 1'b1);
        wait_for(0, 1'b0, 40);
        check("status", link.status, 1'b0);
        request(0);
        wait_for(0, 1'b0, 600);
        check("status", link.status, 1'b1);
        check("running", running, 1'b1);
        check("module_up", module_up, 1'b1);
        request(2);
        wait_for(1, 1'b0, 400);
        wait_for(1, 1'b1, 60);
        check("reset_pulse", n_pulse == 1, 1'b1);
        wait_for(0, 1'b0, 5);
        @(negedge ref_clk) sw_cmd = 1'b1;
        @(negedge ref_clk) sw_cmd = 1'b0;
        wait_for(1, 1'b0, 30);
        check("running", running, 1'b0);
        // Key stays high, so the module must stay down
        repeat (30 * MS) @(negedge ref_clk);
        check("status", link.status, 1'b0);
        check("module_up", module_up, 1'b0);
        request(0);
        wait_for(0, 1'b0, 600);
        check("status", link.status, 1'b1);
        request(1);
        repeat (690 * MS) @(negedge ref_clk);
        check("status", link.status, 1'b1);
        wait_for(1, 1'b0, 40);
        wait_for(0, 1'b0, 5);
        check("running", running, 1'b0);
        finish_test;
    end
endmodule
